// file: bench/host_irq_model.sv
// host side model: pulled-up interrupt wire and a count of interrupts
`timescale 1ns/1ps
module host_irq_model (
   // clock
   input  wire logic sys_clk,
   // device pin
   input  wire logic irq_n_o,
   input  wire logic irq_n_oe,
   // host view
   output logic      irq_line,
   output int        falls
);
   logic line_q = 1'b1;
   // the board pull-up holds the wire high whenever the pin lets go
   assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
   initial falls = 0;
   // sampled on the falling edge, clear of the pin's own update
   always @(negedge sys_clk) begin
      if (line_q && !irq_line)
         falls <= falls + 1;
      line_q <= irq_line;
   end
endmodule : host_irq_model

// file: bench/touch_irq_checker.sv
// assertion checker for the touch threshold interrupt block
`timescale 1ns/1ps
`include "touch_irq_consts.svh"
module touch_irq_checker
   import touch_irq_pkg::*;
#(
   parameter int STAGES = 8
)
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        nrst,
   // register port
   input wire reg_req_s    req,
   input wire logic [15:0] rdata,
   // converter and pin
   input wire conv_s       conv,
   input wire logic        irq_n_o,
   input wire logic        irq_n_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [15:0] low_en_r;
   logic [15:0] high_en_r;
   logic [15:0] done_en_r;
   logic        flag_rd;
   // ---------------------------------------------------------------
   // shadow enables, so readback and firing can be judged
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         low_en_r  <= 16'h0000;
         high_en_r <= 16'h0000;
         done_en_r <= 16'h0000;
      end else if (req.wr) begin
         if (req.addr == `ADDR_LOW_EN) low_en_r <= req.wdata;
         if (req.addr == `ADDR_HIGH_EN) high_en_r <= req.wdata;
         if (req.addr == `ADDR_DONE_EN) done_en_r <= req.wdata;
      end
   end
   assign flag_rd = req.addr_set && (req.addr inside {`ADDR_LOW_FLAGS, `ADDR_HIGH_FLAGS, `ADDR_DONE_FLAGS});
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence done_evt;
      conv.valid && done_en_r[conv.stage] && !req.wr && !flag_rd;
   endsequence
   sequence quiet_cyc;
      !flag_rd && !req.rd && !req.wr;
   endsequence
   od_low_a: assert property (irq_n_o == 1'b0)
      else $error("interrupt pin drives a high level");
   release_a: assert property (flag_rd |=> !irq_n_oe)
      else $error("line not released after status address setup");
   done_fire_a: assert property (done_evt ##1 quiet_cyc |=> irq_n_oe)
      else $error("enabled completion did not pull the line");
   thr_hold_a: assert property (quiet_cyc ##1 (quiet_cyc and irq_n_oe) |=> irq_n_oe)
      else $error("line let go without a status read");
   rise_cause_a: assert property ($rose(irq_n_oe) |->
      $past(conv.valid, 2) || $past(flag_rd, 3) || $past(req.wr, 2) || $past(req.wr, 3))
      else $error("line asserted with no cause");
   rdata_hold_a: assert property (!req.addr_set && !req.rd |=> $stable(rdata))
      else $error("read data moved without a read");
   done_en_rd_a: assert property (req.addr_set && !req.wr && req.addr == `ADDR_DONE_EN
      |=> rdata == done_en_r) else $error("completion enable readback wrong");
   lim_en_rd_a: assert property (req.addr_set && !req.wr && req.addr inside {`ADDR_LOW_EN, `ADDR_HIGH_EN}
      |=> rdata == (($past(req.addr) == `ADDR_LOW_EN) ? low_en_r : high_en_r))
      else $error("limit enable readback wrong");
endmodule : touch_irq_checker

bind touch_irq_core touch_irq_checker #(.STAGES(STAGES)) touch_irq_checker_i (.sys_clk(sys_clk), .nrst(nrst),
   .req(req), .rdata(rdata), .conv(conv), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

// file: bench/touch_threshold_interrupt_logic_bench.sv
// self-checking bench for the touch threshold interrupt block
`timescale 1ns/1ps
`include "touch_irq_consts.svh"
module touch_threshold_interrupt_logic_bench
   import touch_irq_pkg::*;
;
   logic        sys_clk;
   logic        nrst;
   reg_req_s    req;
   logic [15:0] rdata;
   conv_s       conv;
   logic        irq_n_o;
   logic        irq_n_oe;
   logic        irq_line;
   int          falls;
   int          bad_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [9:0]  probe [7] = '{10'h005, 10'h006, 10'h007, 10'h008, 10'h009, 10'h00A, 10'h3FF};

   touch_irq_core #(.STAGES(8)) touch_irq_core_i (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
      .conv(conv), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
   host_irq_model host_irq_model_i (.sys_clk(sys_clk), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
      .irq_line(irq_line), .falls(falls));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic line_chk(input logic seen, input logic exp);
      check({15'h0000, seen}, {15'h0000, exp});
   endtask : line_chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // trip level above ambient for a given offset and sensitivity code
   function automatic logic [15:0] trip_exp(input logic [15:0] amb, input logic [15:0] ofs,
                                            input logic [3:0] sns);
      return amb + ofs / 4 + ((ofs - ofs / 4) / 16) * sns;
   endfunction : trip_exp
   // a spare cycle after each strobe keeps two requests from meeting in one step
   task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      tick(1);
      req.wr = 1'b0;
      tick(1);
   endtask : wr_reg
   task automatic rd_reg(input logic [9:0] a, output logic [15:0] d, output logic l);
      req.addr = a;
      req.addr_set = 1'b1;
      tick(1);
      req.addr_set = 1'b0;
      req.rd = 1'b1;
      d = rdata;
      l = irq_line;
      tick(1);
      req.rd = 1'b0;
      tick(1);
   endtask : rd_reg
   task automatic send(input logic [2:0] s, input logic [15:0] r);
      conv.stage = s;
      conv.result = r;
      conv.valid = 1'b1;
      tick(1);
      conv.valid = 1'b0;
      tick(2);
   endtask : send

   // ---------------------------------------------------------------
   // clock, timeout and main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      logic [15:0] d;
      logic [15:0] e;
      logic        l;
      int          s;
      int          t;
      nrst = 1'b0;
      req = '0;
      conv = '0;
      void'($urandom(32'hE885));
      tick(5);
      nrst = 1'b1;
      tick(1);
      for (int i = 0; i < 7; i++) begin
         rd_reg(probe[i], d, l);
         check(d, 16'h0000);
         line_chk(l, 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
         e = 16'($urandom);
         wr_reg(`ADDR_LOW_EN + 10'(i), e);
         rd_reg(`ADDR_LOW_EN + 10'(i), d, l);
         check(d, e);
         wr_reg(`ADDR_LOW_EN + 10'(i), 16'h0000);
      end
      // touch and lift-off on stage 0, high offset seeded at 80% of the high bound
      wr_reg(`ADDR_SENS, 16'h0800);
      wr_reg(`ADDR_STAGE_BASE + 10'(`SLOT_HIGH_BOUND), 16'h0140);
      wr_reg(`ADDR_STAGE_BASE + 10'(`SLOT_HIGH_OFS), 16'h0100);
      wr_reg(`ADDR_HIGH_EN, 16'h0001);
      send(3'h0, 16'hFFFF);
      line_chk(irq_line, 1'b0);
      tick(6);
      line_chk(irq_line, 1'b0);
      rd_reg(`ADDR_HIGH_FLAGS, d, l);
      check(d, 16'h0001);
      line_chk(l, 1'b1);
      rd_reg(`ADDR_HIGH_FLAGS, d, l);
      check(d, 16'h0001);
      line_chk(irq_line, 1'b1);
      send(3'h0, 16'h0000);
      line_chk(irq_line, 1'b0);
      rd_reg(`ADDR_HIGH_FLAGS, d, l);
      check(d, 16'h0000);
      // max average is the mean of zero and the touch sample; ambient saw only untouched zeros
      rd_reg(`ADDR_STAGE_BASE + 10'(`SLOT_MAX_AVG), d, l);
      check(d, 16'h7FFF);
      rd_reg(`ADDR_STAGE_BASE + 10'(`SLOT_AMBIENT), d, l);
      check(d, 16'h0000);
      rd_reg(`ADDR_STAGE_BASE + 10'(`SLOT_HIGH_OFS), d, l);
      check(d, 16'h0140);
      rd_reg(`ADDR_STAGE_BASE + 10'(`SLOT_HIGH_TRIP), d, l);
      check(d, trip_exp(16'h0000, 16'h0140, 4'h8));
      wr_reg(`ADDR_HIGH_EN, 16'h0000);
      // completion interrupt on one random stage, another stage disabled
      repeat (4) begin
         s = $urandom_range(7);
         t = (s + 1 + $urandom_range(6)) % 8;
         wr_reg(`ADDR_DONE_EN, 16'h0001 << s);
         send(3'(t), 16'($urandom));
         line_chk(irq_line, 1'b1);
         send(3'(s), 16'($urandom));
         line_chk(irq_line, 1'b0);
         rd_reg(`ADDR_DONE_FLAGS, d, l);
         check(d & (16'h0001 << s), 16'h0001 << s);
         line_chk(l, 1'b1);
         rd_reg(`ADDR_DONE_FLAGS, d, l);
         check(d & (16'h0001 << s), 16'h0000);
         line_chk(irq_line, 1'b1);
      end
      tick(2);
      check(16'(falls), 16'h0006);
      give_verdict();
   end
endmodule : touch_threshold_interrupt_logic_bench

// file: verilog/stage_trip_calc.sv
// threshold arithmetic for one stage: ambient + off/4 + (off - off/4)/16 * sens
`timescale 1ns/1ps
module stage_trip_calc
   import touch_irq_pkg::*;
(
   // operands
   input  wire logic [15:0] ambient,
   input  wire logic [15:0] offset,
   input  wire logic [3:0]  sens,
   // result
   output logic      [15:0] trip
);
   logic [15:0] quarter;
   logic [15:0] step;
   logic [19:0] scaled;
   always_comb begin
      quarter = offset >> 2;
      step    = (offset - quarter) >> 4;
      scaled  = step * sens;
      trip    = ambient + quarter + scaled[15:0];
   end
endmodule : stage_trip_calc

// file: verilog/touch_irq_consts.svh
// constants for the touch threshold interrupt block
`ifndef TOUCH_IRQ_CONSTS_SVH
`define TOUCH_IRQ_CONSTS_SVH
`define ADDR_LOW_EN      10'h005
`define ADDR_HIGH_EN     10'h006
`define ADDR_DONE_EN     10'h007
`define ADDR_LOW_FLAGS   10'h008
`define ADDR_HIGH_FLAGS  10'h009
`define ADDR_DONE_FLAGS  10'h00A
`define ADDR_SENS        10'h00B
`define ADDR_STAGE_BASE  10'h040
`define STAGE_STRIDE     4'h8
`define SLOT_LOW_OFS     3'h0
`define SLOT_HIGH_OFS    3'h1
`define SLOT_HIGH_BOUND  3'h2
`define SLOT_LOW_BOUND   3'h3
`define SLOT_AMBIENT     3'h4
`define SLOT_HIGH_TRIP   3'h5
`define SLOT_LOW_TRIP    3'h6
`define SLOT_MAX_AVG     3'h7
`define SENS_NEG_LSB     0
`define SENS_NEG_PEAK    4
`define SENS_POS_LSB     8
`define SENS_POS_PEAK    12
`define EN_RESET         16'h0000
`define AMBIENT_SHIFT    3
`define PEAK_SHIFT       2
`endif

// file: verilog/touch_irq_core.sv
// per-stage calibration bookkeeping and interrupt logic of the touch controller
`timescale 1ns/1ps
`include "touch_irq_consts.svh"

module touch_irq_core
   import touch_irq_pkg::*;
#(
   parameter int STAGES = 8
)
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // register port from the serial slave
   input  wire reg_req_s    req,
   output logic      [15:0] rdata,
   // converter results
   input  wire conv_s       conv,
   // interrupt pin, open drain
   output logic             irq_n_o,
   output logic             irq_n_oe
);
   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [15:0] low_en_r;
   logic [15:0] high_en_r;
   logic [15:0] done_en_r;
   logic [15:0] low_flags_r;
   logic [15:0] high_flags_r;
   logic [15:0] done_flags_r;
   logic [15:0] sens_r;
   logic [15:0] low_ofs_r   [STAGES];
   logic [15:0] high_ofs_r  [STAGES];
   logic [15:0] high_bnd_r  [STAGES];
   logic [15:0] low_bnd_r   [STAGES];
   logic [15:0] ambient_r   [STAGES];
   logic [15:0] min_avg_r   [STAGES];
   logic [15:0] max_avg_r   [STAGES];
   logic [15:0] high_trip_r [STAGES];
   logic [15:0] low_trip_r  [STAGES];
   logic [STAGES-1:0] high_act;
   logic [STAGES-1:0] low_act;
   logic [STAGES-1:0] high_act_r;
   logic [STAGES-1:0] low_act_r;
   logic        thr_pend_r;
   logic        rd_lock_r;
   logic        conv_hold_r;
   logic [2:0]  conv_stage_r;
   logic        irq_nxt;
   logic        flag_addr_set;

   // stage window decode
   logic        stage_hit;
   logic [2:0]  stage_sel;
   logic [2:0]  slot_sel;
   logic [9:0]  stage_rel;
   always_comb begin
      stage_rel = req.addr - `ADDR_STAGE_BASE;
      stage_hit = (req.addr >= `ADDR_STAGE_BASE) &&
                  (stage_rel < 10'(STAGES * `STAGE_STRIDE));
      stage_sel = stage_rel[5:3];
      slot_sel  = stage_rel[2:0];
   end

   // ---------------------------------------------------------------
   // enables and sensitivity
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         low_en_r  <= `EN_RESET;
         high_en_r <= `EN_RESET;
         done_en_r <= `EN_RESET;
         sens_r    <= 16'h0000;
      end else if (req.wr) begin
         unique case (req.addr)
            `ADDR_LOW_EN:  low_en_r  <= req.wdata;
            `ADDR_HIGH_EN: high_en_r <= req.wdata;
            `ADDR_DONE_EN: done_en_r <= req.wdata;
            `ADDR_SENS:    sens_r    <= req.wdata;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // per-stage calibration
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : g_stage
         logic        hit;
         logic [15:0] res;
         logic [15:0] max_span;
         logic [15:0] min_span;
         logic [15:0] max_gate;
         logic [15:0] min_gate;
         logic [15:0] drift;
         logic [15:0] hi_calc;
         logic [15:0] lo_calc;
         logic [15:0] hi_ofs_new;
         logic [15:0] lo_ofs_new;
         always_comb begin
            hit      = conv.valid && (conv.stage == 3'(g));
            res      = conv.result;
            max_span = max_avg_r[g] - ambient_r[g];
            min_span = ambient_r[g] - min_avg_r[g];
            // gate is a quarter-step fraction of the span
            // product kept at 20 bits so a wide span cannot wrap before the scale-down
            max_gate = 16'((20'(max_span >> `PEAK_SHIFT) * 20'(sens_r[`SENS_POS_PEAK +: 4])) >> 4);
            min_gate = 16'((20'(min_span >> `PEAK_SHIFT) * 20'(sens_r[`SENS_NEG_PEAK +: 4])) >> 4);
            drift    = res - ambient_r[g];
            // clamp offsets within the bounds
            hi_ofs_new = (drift > high_bnd_r[g]) ? high_bnd_r[g] : drift;
            lo_ofs_new = ((ambient_r[g] - res) > low_bnd_r[g]) ? low_bnd_r[g]
                         : (ambient_r[g] - res);
         end

         stage_trip_calc u_hi (
            .ambient (ambient_r[g]),
            .offset  (high_ofs_r[g]),
            .sens    (sens_r[`SENS_POS_LSB +: 4]),
            .trip    (hi_calc)
         );
         stage_trip_calc u_lo (
            .ambient (ambient_r[g]),
            .offset  (low_ofs_r[g]),
            .sens    (sens_r[`SENS_NEG_LSB +: 4]),
            .trip    (lo_calc)
         );

         // ambient follows only while untouched
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               ambient_r[g] <= 16'h0000;
            end else if (hit && !high_act[g] && !low_act[g]) begin
               ambient_r[g] <= ambient_r[g] + 16'((32'(res) - 32'(ambient_r[g])) >>> `AMBIENT_SHIFT);
            end
         end

         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               max_avg_r[g] <= 16'h0000;
               min_avg_r[g] <= 16'h0000;
            end else if (hit) begin
               if (res >= max_avg_r[g] - max_gate)
                  max_avg_r[g] <= 16'((32'(max_avg_r[g]) + 32'(res)) >> 1);
               if (res <= min_avg_r[g] + min_gate)
                  min_avg_r[g] <= 16'((32'(min_avg_r[g]) + 32'(res)) >> 1);
            end
         end

         // offsets: host writes seed them, touches retune them
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               high_ofs_r[g] <= 16'h0000;
               low_ofs_r[g]  <= 16'h0000;
               high_bnd_r[g] <= 16'h0000;
               low_bnd_r[g]  <= 16'h0000;
            end else if (req.wr && stage_hit && stage_sel == 3'(g)) begin
               unique case (slot_sel)
                  `SLOT_LOW_OFS:    low_ofs_r[g]  <= req.wdata;
                  `SLOT_HIGH_OFS:   high_ofs_r[g] <= req.wdata;
                  `SLOT_HIGH_BOUND: high_bnd_r[g] <= req.wdata;
                  `SLOT_LOW_BOUND:  low_bnd_r[g]  <= req.wdata;
                  default: ;
               endcase
            end else if (hit && high_act[g]) begin
               high_ofs_r[g] <= hi_ofs_new;
            end else if (hit && low_act[g]) begin
               low_ofs_r[g] <= lo_ofs_new;
            end
         end

         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               high_trip_r[g] <= 16'h0000;
               low_trip_r[g]  <= 16'h0000;
            end else begin
               high_trip_r[g] <= hi_calc;
               low_trip_r[g]  <= ambient_r[g] - (lo_calc - ambient_r[g]);
            end
         end

         // activation state held from the last result of the stage
         always_ff @(posedge sys_clk) begin
            if (!nrst) begin
               high_act_r[g] <= 1'b0;
               low_act_r[g]  <= 1'b0;
            end else if (hit) begin
               high_act_r[g] <= high_act[g];
               low_act_r[g]  <= low_act[g];
            end
         end

         always_comb begin
            high_act[g] = hit ? (res > high_trip_r[g]) : high_act_r[g];
            low_act[g]  = hit ? (res < low_trip_r[g])  : low_act_r[g];
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   logic rd_low;
   logic rd_high;
   logic rd_done;
   logic [STAGES-1:0] thr_change;
   logic [STAGES-1:0] done_set;
   always_comb begin
      rd_low     = req.rd && req.addr == `ADDR_LOW_FLAGS;
      rd_high    = req.rd && req.addr == `ADDR_HIGH_FLAGS;
      rd_done    = req.rd && req.addr == `ADDR_DONE_FLAGS;
      thr_change = ((high_act ^ high_act_r) & high_en_r[STAGES-1:0]) |
                   ((low_act ^ low_act_r) & low_en_r[STAGES-1:0]);
      done_set   = '0;
      if (conv.valid)
         done_set[conv.stage] = done_en_r[conv.stage];
   end

   // threshold status mirrors present state of enabled stages
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         low_flags_r  <= 16'h0000;
         high_flags_r <= 16'h0000;
      end else begin
         low_flags_r  <= 16'(low_act & low_en_r[STAGES-1:0]);
         high_flags_r <= 16'(high_act & high_en_r[STAGES-1:0]);
      end
   end

   // a change latches a pending event until a threshold status read
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         thr_pend_r <= 1'b0;
      else if (|thr_change)
         thr_pend_r <= 1'b1;             // set wins over clear
      else if (rd_low || rd_high)
         thr_pend_r <= 1'b0;
   end

   // done flag: a read clears it unless a new completion lands now
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         done_flags_r <= 16'h0000;
      else if (rd_done)
         done_flags_r <= 16'(done_set);
      else
         done_flags_r <= done_flags_r | 16'(done_set);
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rdata <= 16'h0000;
      end else if (req.addr_set || req.rd) begin
         if (stage_hit) begin
            unique case (slot_sel)
               `SLOT_LOW_OFS:    rdata <= low_ofs_r[stage_sel];
               `SLOT_HIGH_OFS:   rdata <= high_ofs_r[stage_sel];
               `SLOT_HIGH_BOUND: rdata <= high_bnd_r[stage_sel];
               `SLOT_LOW_BOUND:  rdata <= low_bnd_r[stage_sel];
               `SLOT_AMBIENT:    rdata <= ambient_r[stage_sel];
               `SLOT_HIGH_TRIP:  rdata <= high_trip_r[stage_sel];
               `SLOT_LOW_TRIP:   rdata <= low_trip_r[stage_sel];
               `SLOT_MAX_AVG:    rdata <= max_avg_r[stage_sel];
               default:          rdata <= 16'h0000;
            endcase
         end else begin
            unique case (req.addr)
               `ADDR_LOW_EN:     rdata <= low_en_r;
               `ADDR_HIGH_EN:    rdata <= high_en_r;
               `ADDR_DONE_EN:    rdata <= done_en_r;
               `ADDR_LOW_FLAGS:  rdata <= low_flags_r;
               `ADDR_HIGH_FLAGS: rdata <= high_flags_r;
               `ADDR_DONE_FLAGS: rdata <= done_flags_r;
               `ADDR_SENS:       rdata <= sens_r;
               default:          rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt line
   // ---------------------------------------------------------------
   // releasing on address setup lets the host see the line go high
   // before the read data is even clocked out
   always_comb begin
      flag_addr_set = req.addr_set && (req.addr == `ADDR_LOW_FLAGS ||
                      req.addr == `ADDR_HIGH_FLAGS || req.addr == `ADDR_DONE_FLAGS);
   end

   // the lock keeps the line released through the read strobe that follows
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         rd_lock_r <= 1'b0;
      else
         rd_lock_r <= flag_addr_set;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         conv_stage_r <= 3'h0;
      else if (conv.valid)
         conv_stage_r <= conv.stage;
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         conv_hold_r <= 1'b0;
      else
         conv_hold_r <= |done_flags_r;
   end

   always_comb begin
      irq_nxt = !((thr_pend_r || (|(done_flags_r & done_en_r))) && !flag_addr_set && !rd_lock_r);
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         irq_n_o  <= 1'b0;
         irq_n_oe <= 1'b0;
      end else begin
         irq_n_o  <= 1'b0;
         irq_n_oe <= !irq_nxt;
      end
   end
endmodule : touch_irq_core

// file: verilog/touch_irq_pkg.sv
// types shared by the touch threshold interrupt block
package touch_irq_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        addr_set;
      logic [9:0]  addr;
      logic [15:0] wdata;
   } reg_req_s;
   typedef struct packed {
      logic        valid;
      logic [2:0]  stage;
      logic [15:0] result;
   } conv_s;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CALC = 2'b01,
      ST_DONE = 2'b10
   } calc_e;
endpackage : touch_irq_pkg
